// *** verilog/ogd_pkg.sv ***
// Constants for the output-group divider and channel-routing block.
// Assumes the serial control port presents decoded register cycles.
`default_nettype none
package ogd_pkg;
	// ------------------------------------------------------------
	// Register bus widths and addresses
	// ------------------------------------------------------------
	localparam int          ADDR_W           = 10;
	localparam int          DATA_W           = 8;
	localparam logic [9:0]  ADDR_DIV1_COUNTS = 10'h193;
	localparam logic [9:0]  ADDR_DIV1_CTRL   = 10'h194;
	localparam logic [9:0]  ADDR_CHAN1_CTRL  = 10'h195;
	localparam logic [9:0]  ADDR_DIV2_COUNTS = 10'h196;
	localparam logic [9:0]  ADDR_DIV2_CTRL   = 10'h197;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          BIT_BYPASS       = 7;
	localparam int          BIT_IGNORE_SYNC  = 6;
	localparam int          BIT_FORCE_HIGH   = 5;
	localparam int          BIT_START_HIGH   = 4;
	localparam int          PHASE_LSB        = 0;
	localparam int          LOW_LSB          = 4;
	localparam int          HIGH_LSB         = 0;
	localparam int          FIELD_W          = 4;
	localparam int          BIT_POWER_DOWN   = 2;
	localparam int          BIT_DIRECT       = 1;
	localparam int          BIT_DCC_DISABLE  = 0;
	// ------------------------------------------------------------
	// Reset values, write masks and unmapped read value
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_DIV1_COUNTS  = 8'h33;
	localparam logic [7:0]  RST_DIV1_CTRL    = 8'h00;
	localparam logic [7:0]  RST_CHAN1_CTRL   = 8'h00;
	localparam logic [7:0]  RST_DIV2_COUNTS  = 8'h11;
	localparam logic [7:0]  RST_DIV2_CTRL    = 8'h00;
	localparam logic [7:0]  CHAN1_MASK       = 8'h07;
	localparam logic [7:0]  DIV2_CTRL_MASK   = 8'h80;
	localparam logic [7:0]  READ_UNMAPPED    = 8'h00;
	// ------------------------------------------------------------
	// Direct-route source codes and clock pin synchroniser constants
	// ------------------------------------------------------------
	localparam logic [1:0]  SRC_OSC          = 2'h2;
	localparam logic [1:0]  SRC_EXT          = 2'h0;
	localparam int          SYNC_STAGES      = 3;
	localparam int          NUM_PINS         = 2;
	localparam int          PIN_OSC          = 0;
	localparam int          PIN_EXT          = 1;
endpackage
`default_nettype wire

// *** verilog/ogd_divider.sv ***
// One output divider: low/high counts, phase delay, start level,
// bypass, force and synchronisation handling.
// Assumes in_tick_in marks one rising edge of the divider input clock.
`timescale 1ns/100ps
`default_nettype none
module ogd_divider
	import ogd_pkg::*;
(
	input  wire logic               core_clk_in,    // Core clock
	input  wire logic               resetn_in,      // Async reset, low
	input  wire logic               in_tick_in,     // Input clock edge
	input  wire logic               in_level_in,    // Input clock level
	input  wire logic               bypass_in,      // Bypass divider
	input  wire logic               ignore_sync_in, // Ignore sync
	input  wire logic               force_high_in,  // Force output high
	input  wire logic               start_high_in,  // Start level
	input  wire logic [FIELD_W-1:0] phase_in,       // Phase offset
	input  wire logic [FIELD_W-1:0] low_in,         // Low cycles - 1
	input  wire logic [FIELD_W-1:0] high_in,        // High cycles - 1
	input  wire logic               sync_in,        // Chip-level sync
	output logic                    div_out         // Divider output
);
	typedef enum logic [1:0] {OGD_RUN, OGD_HOLD, OGD_DELAY} ogd_state_t;

	ogd_state_t         state_r, state_nxt;
	logic [FIELD_W-1:0] cnt_r, cnt_nxt;
	logic               out_r, out_nxt;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		out_nxt   = out_r;
		if (bypass_in) begin
			state_nxt = OGD_HOLD;
			out_nxt   = in_level_in;
		end else if (ignore_sync_in && force_high_in) begin
			state_nxt = OGD_HOLD;
			out_nxt   = 1'b1;
		end else if (sync_in && !ignore_sync_in) begin
			state_nxt = OGD_HOLD;
			out_nxt   = start_high_in;
		end else begin
			unique case (state_r)
				OGD_HOLD: begin
					if (phase_in != '0) begin
						state_nxt = OGD_DELAY;
						cnt_nxt   = phase_in;
					end else begin
						state_nxt = OGD_RUN;
						cnt_nxt   = out_r ? high_in : low_in;
					end
				end
				OGD_DELAY: begin
					if (in_tick_in) begin
						if (cnt_r == FIELD_W'(1)) begin
							state_nxt = OGD_RUN;
							cnt_nxt   = out_r ? high_in : low_in;
						end else begin
							cnt_nxt = cnt_r - FIELD_W'(1);
						end
					end
				end
				OGD_RUN: begin
					if (in_tick_in) begin
						if (cnt_r == '0) begin
							out_nxt = !out_r;
							cnt_nxt = out_r ? low_in : high_in;
						end else begin
							cnt_nxt = cnt_r - FIELD_W'(1);
						end
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= OGD_HOLD;
			cnt_r   <= '0;
			out_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			out_r   <= out_nxt;
		end
	end

	assign div_out = out_r;
endmodule
`default_nettype wire

// *** verilog/ogd_top.sv ***
// Output group 1 divider, channel 1 routing and divider 2 counts/bypass.
// Assumes the serial control port gives single-cycle register strobes
// on core_clk_in and that clock pins toggle well below 20 MHz.
//
// Function
// - A set bypass bit powers the divider down and passes its input.
// - The divider obeys chip sync unless its ignore-sync bit is set.
// - Force-high sets a static output level; software sets ignore-sync.
// - Start-high picks the output level at which the divider begins.
// - A four-bit phase offset, reset zero, delays the output in cycles.
// - Channel power-down puts all three group outputs in safe state.
// - With direct clear the group outputs come from the divider.
// - With direct set, source 10b feeds the oscillator, 00b the clock.
// - Duty-cycle correction runs unless its disable bit is set.
// - Output stays low for the low field plus one input cycles.
// - Output stays high for the high field plus one input cycles.
// - Divider 1 low and high fields reset to 0x3 each.
`timescale 1ns/100ps
`default_nettype none
module ogd_top
	import ogd_pkg::*;
(
	input  wire logic              core_clk_in,                // 40 MHz
	input  wire logic              resetn_in,                  // Reset, low
	input  wire logic [ADDR_W-1:0] reg_addr_in,                // Reg address
	input  wire logic [DATA_W-1:0] reg_wdata_in,               // Write data
	input  wire logic              reg_wr_in,                  // Write strobe
	input  wire logic              reg_rd_in,                  // Read strobe
	input  wire logic [1:0]        clk_source_sel_in,          // Source code
	input  wire logic              sync_in,                    // Chip sync
	input  wire logic              internal_oscillator_in,     // Osc pin
	input  wire logic              ext_clk_in,                 // Ext clk pin
	output logic [DATA_W-1:0]      reg_rdata_out,              // Read data
	output logic                   group1_output_a_out,        // Output a
	output logic                   group1_output_b_out,        // Output b
	output logic                   group1_output_c_out,        // Output c
	output logic                   group1_power_down_out,      // Safe state
	output logic                   duty_cycle_correction_out,  // DCC enable
	output logic                   div2_clk_out                // Divider 2
);
	logic [DATA_W-1:0] div1_counts_r,  div1_counts_nxt;
	logic [DATA_W-1:0] div1_ctrl_r,    div1_ctrl_nxt;
	logic [DATA_W-1:0] chan1_ctrl_r,   chan1_ctrl_nxt;
	logic [DATA_W-1:0] div2_counts_r,  div2_counts_nxt;
	logic [DATA_W-1:0] div2_ctrl_r,    div2_ctrl_nxt;
	logic [DATA_W-1:0] rdata_r,        rdata_nxt;
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] pin_lvl;
	logic [NUM_PINS-1:0] pin_tick;
	logic              div_in_level, div_in_tick;
	logic              div1_q, div2_q;
	logic              grp_r, grp_nxt;
	logic              pd_r, pd_nxt;
	logic              dcc_r, dcc_nxt;
	logic              d2_r, d2_nxt;

	// Selects a register image by address; unmapped reads as zero
	function automatic logic [DATA_W-1:0] read_mux(
		input logic [ADDR_W-1:0] addr,
		input logic [DATA_W-1:0] c1,
		input logic [DATA_W-1:0] k1,
		input logic [DATA_W-1:0] h1,
		input logic [DATA_W-1:0] c2,
		input logic [DATA_W-1:0] k2
	);
		logic [DATA_W-1:0] v;
		v = READ_UNMAPPED;
		unique case (addr)
			ADDR_DIV1_COUNTS: v = c1;
			ADDR_DIV1_CTRL:   v = k1;
			ADDR_CHAN1_CTRL:  v = h1;
			ADDR_DIV2_COUNTS: v = c2;
			ADDR_DIV2_CTRL:   v = k2;
			default:          v = READ_UNMAPPED;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------
	// Clock pin synchronisers
	// ------------------------------------------------------------
	assign pin_raw[PIN_OSC] = internal_oscillator_in;
	assign pin_raw[PIN_EXT] = ext_clk_in;

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_pin
			logic [SYNC_STAGES-1:0] sh_r, sh_nxt;
			logic                   lvl_r, lvl_nxt;
			always_comb begin
				sh_nxt  = {sh_r[SYNC_STAGES-2:0], pin_raw[g]};
				lvl_nxt = lvl_r;
				// Level changes once stages two and three agree
				if (sh_r[1] == sh_r[2]) begin
					lvl_nxt = sh_r[2];
				end
			end
			always_ff @(posedge core_clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					sh_r  <= '0;
					lvl_r <= 1'b0;
				end else begin
					sh_r  <= sh_nxt;
					lvl_r <= lvl_nxt;
				end
			end
			assign pin_lvl[g]  = lvl_r;
			assign pin_tick[g] = lvl_nxt && !lvl_r;
		end
	endgenerate

	assign div_in_level = clk_source_sel_in[1] ? pin_lvl[PIN_OSC]
		: pin_lvl[PIN_EXT];
	assign div_in_tick  = clk_source_sel_in[1] ? pin_tick[PIN_OSC]
		: pin_tick[PIN_EXT];

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	always_comb begin
		div1_counts_nxt = div1_counts_r;
		div1_ctrl_nxt   = div1_ctrl_r;
		chan1_ctrl_nxt  = chan1_ctrl_r;
		div2_counts_nxt = div2_counts_r;
		div2_ctrl_nxt   = div2_ctrl_r;
		rdata_nxt       = rdata_r;
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				ADDR_DIV1_COUNTS: div1_counts_nxt = reg_wdata_in;
				ADDR_DIV1_CTRL:   div1_ctrl_nxt   = reg_wdata_in;
				ADDR_CHAN1_CTRL:  chan1_ctrl_nxt  = reg_wdata_in & CHAN1_MASK;
				ADDR_DIV2_COUNTS: div2_counts_nxt = reg_wdata_in;
				ADDR_DIV2_CTRL:   div2_ctrl_nxt   = reg_wdata_in & DIV2_CTRL_MASK;
				default: begin
				end
			endcase
		end
		if (reg_rd_in) begin
			rdata_nxt = read_mux(reg_addr_in, div1_counts_r, div1_ctrl_r,
				chan1_ctrl_r, div2_counts_r, div2_ctrl_r);
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div1_counts_r <= RST_DIV1_COUNTS;
			div1_ctrl_r   <= RST_DIV1_CTRL;
			chan1_ctrl_r  <= RST_CHAN1_CTRL;
			div2_counts_r <= RST_DIV2_COUNTS;
			div2_ctrl_r   <= RST_DIV2_CTRL;
			rdata_r       <= READ_UNMAPPED;
		end else begin
			div1_counts_r <= div1_counts_nxt;
			div1_ctrl_r   <= div1_ctrl_nxt;
			chan1_ctrl_r  <= chan1_ctrl_nxt;
			div2_counts_r <= div2_counts_nxt;
			div2_ctrl_r   <= div2_ctrl_nxt;
			rdata_r       <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Dividers
	// ------------------------------------------------------------
	ogd_divider u_div1 (
		.core_clk_in    (core_clk_in),
		.resetn_in      (resetn_in),
		.in_tick_in     (div_in_tick),
		.in_level_in    (div_in_level),
		.bypass_in      (div1_ctrl_r[BIT_BYPASS]),
		.ignore_sync_in (div1_ctrl_r[BIT_IGNORE_SYNC]),
		.force_high_in  (div1_ctrl_r[BIT_FORCE_HIGH]),
		.start_high_in  (div1_ctrl_r[BIT_START_HIGH]),
		.phase_in       (div1_ctrl_r[PHASE_LSB +: FIELD_W]),
		.low_in         (div1_counts_r[LOW_LSB +: FIELD_W]),
		.high_in        (div1_counts_r[HIGH_LSB +: FIELD_W]),
		.sync_in        (sync_in),
		.div_out        (div1_q)
	);

	// Divider 2 keeps only counts and bypass here; other bits held clear
	ogd_divider u_div2 (
		.core_clk_in    (core_clk_in),
		.resetn_in      (resetn_in),
		.in_tick_in     (div_in_tick),
		.in_level_in    (div_in_level),
		.bypass_in      (div2_ctrl_r[BIT_BYPASS]),
		.ignore_sync_in (1'b0),
		.force_high_in  (1'b0),
		.start_high_in  (1'b0),
		.phase_in       ('0),
		.low_in         (div2_counts_r[LOW_LSB +: FIELD_W]),
		.high_in        (div2_counts_r[HIGH_LSB +: FIELD_W]),
		.sync_in        (sync_in),
		.div_out        (div2_q)
	);

	// ------------------------------------------------------------
	// Channel 1 routing
	// ------------------------------------------------------------
	always_comb begin
		grp_nxt = div1_q;
		if (chan1_ctrl_r[BIT_DIRECT]) begin
			if (clk_source_sel_in == SRC_OSC) begin
				grp_nxt = pin_lvl[PIN_OSC];
			end else if (clk_source_sel_in == SRC_EXT) begin
				grp_nxt = pin_lvl[PIN_EXT];
			end
		end
		pd_nxt = chan1_ctrl_r[BIT_POWER_DOWN];
		if (pd_nxt) begin
			grp_nxt = 1'b0;
		end
		dcc_nxt = !chan1_ctrl_r[BIT_DCC_DISABLE];
		d2_nxt  = div2_q;
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			grp_r <= 1'b0;
			pd_r  <= 1'b0;
			dcc_r <= 1'b1;
			d2_r  <= 1'b0;
		end else begin
			grp_r <= grp_nxt;
			pd_r  <= pd_nxt;
			dcc_r <= dcc_nxt;
			d2_r  <= d2_nxt;
		end
	end

	assign reg_rdata_out             = rdata_r;
	assign group1_output_a_out       = grp_r;
	assign group1_output_b_out       = grp_r;
	assign group1_output_c_out       = grp_r;
	assign group1_power_down_out     = pd_r;
	assign duty_cycle_correction_out = dcc_r;
	assign div2_clk_out              = d2_r;
endmodule
`default_nettype wire

// *** verification/ogd_top_sva.sv ***
// Checker for group 1 outputs, power-down, correction and divider 2 sync.
// Assumes it is bound into ogd_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ogd_top_chk
	import ogd_pkg::*;
(
	input wire logic              core_clk_in,               // Clock
	input wire logic              resetn_in,                 // Reset
	input wire logic [ADDR_W-1:0] reg_addr_in,               // Address
	input wire logic [DATA_W-1:0] reg_wdata_in,              // Data
	input wire logic              reg_wr_in,                 // Write
	input wire logic              sync_in,                   // Sync
	input wire logic              group1_output_a_out,       // Out a
	input wire logic              group1_output_b_out,       // Out b
	input wire logic              group1_output_c_out,       // Out c
	input wire logic              group1_power_down_out,     // Safe
	input wire logic              duty_cycle_correction_out, // DCC
	input wire logic              div2_clk_out               // Div 2
);
	// ------------------------------------------------------------
	// Divider 2 bypass shadow
	// ------------------------------------------------------------
	logic byp2_r;
	logic byp2_nxt;
	always_comb begin
		byp2_nxt = byp2_r;
		if (reg_wr_in && reg_addr_in == ADDR_DIV2_CTRL)
			byp2_nxt = reg_wdata_in[BIT_BYPASS];
	end
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			byp2_r <= 1'b0;
		else
			byp2_r <= byp2_nxt;
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_ch_wr;
		reg_wr_in && reg_addr_in == ADDR_CHAN1_CTRL;
	endsequence
	sequence s_sync_held;
		(sync_in && !byp2_r) [*8];
	endsequence
	grp_same_a: assert property (
		{group1_output_b_out, group1_output_c_out} ==
		{2{group1_output_a_out}}) else $error("group outputs differ");
	pd_quiet_a: assert property (
		group1_power_down_out |-> !group1_output_a_out)
		else $error("output active in power-down");
	pd_set_a: assert property (
		s_ch_wr ##0 reg_wdata_in[BIT_POWER_DOWN] |-> ##[1:3]
		group1_power_down_out) else $error("power-down not entered");
	pd_clr_a: assert property (
		s_ch_wr ##0 !reg_wdata_in[BIT_POWER_DOWN] |-> ##[1:3]
		!group1_power_down_out) else $error("power-down not left");
	dcc_off_a: assert property (
		s_ch_wr ##0 reg_wdata_in[BIT_DCC_DISABLE] |-> ##[1:3]
		!duty_cycle_correction_out) else $error("correction not off");
	dcc_on_a: assert property (
		s_ch_wr ##0 !reg_wdata_in[BIT_DCC_DISABLE] |-> ##[1:3]
		duty_cycle_correction_out) else $error("correction not on");
	rst_state_a: assert property (
		$rose(resetn_in) |-> duty_cycle_correction_out &&
		!group1_power_down_out) else $error("bad state after reset");
	sync_hold_a: assert property (
		s_sync_held |-> !div2_clk_out)
		else $error("divider 2 runs during sync");
endmodule
bind ogd_top ogd_top_chk u_chk (.core_clk_in, .resetn_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .sync_in, .group1_output_a_out,
	.group1_output_b_out, .group1_output_c_out, .group1_power_down_out,
	.duty_cycle_correction_out, .div2_clk_out);
`default_nettype wire

// *** verification/test_output_group_divider_config.sv ***
// Self-checking bench for ogd_top: registers, dividers and routing.
// Pin clocks are derived from the core clock by a counter.
`timescale 1ns/100ps
`default_nettype none
module test_output_group_divider_config;
	import ogd_pkg::*;
	logic              clk   = 1'b0;
	logic              rstn  = 1'b0;
	logic [ADDR_W-1:0] addr  = 10'h000;
	logic [DATA_W-1:0] wdata = 8'h00;
	logic              wr    = 1'b0;
	logic              rd    = 1'b0;
	logic [1:0]        sel   = 2'h2;
	logic              sync  = 1'b0;
	logic              osc   = 1'b0;
	logic              ext   = 1'b0;
	logic [7:0]        ph    = 8'h00;
	logic [DATA_W-1:0] rdata;
	logic              ga, gb, gc, pd, dcc, d2;
	int                n_fail      = 0;
	int                checks_done = 0;
	always #12.5 clk = ~clk;
	// Oscillator pin period 8 cycles, external pin 16
	always @(posedge clk) begin
		ph <= ph + 8'h01;
		osc <= ph[2];
		ext <= ph[3];
	end
	ogd_top uut (.core_clk_in(clk), .resetn_in(rstn), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.clk_source_sel_in(sel), .sync_in(sync),
		.internal_oscillator_in(osc), .ext_clk_in(ext),
		.reg_rdata_out(rdata), .group1_output_a_out(ga),
		.group1_output_b_out(gb), .group1_output_c_out(gc),
		.group1_power_down_out(pd), .duty_cycle_correction_out(dcc),
		.div2_clk_out(d2));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wreg(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [9:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	function automatic logic pick(input bit w);
		return w ? d2 : ga;
	endfunction
	task automatic run(input bit w, input logic v, output int n);
		n = 0;
		while (pick(w) === v && n < 500) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic mchk(input bit w, input int eh, input int el);
		int n;
		int h;
		int l;
		@(negedge clk);
		run(w, 1'b0, n);
		run(w, 1'b1, n);
		run(w, 1'b0, n);
		run(w, 1'b1, h);
		run(w, 1'b0, l);
		chk("high cycles", 16'(eh), 16'(h));
		chk("low cycles", 16'(el), 16'(l));
		if (!w) chk("outputs b c", 16'({ga, ga}), 16'({gb, gc}));
	endtask
	task automatic setsel(input logic [1:0] s);
		@(posedge clk);
		sel <= s;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [9:0] ad [6] = '{ADDR_DIV1_COUNTS, ADDR_DIV1_CTRL,
			ADDR_CHAN1_CTRL, ADDR_DIV2_COUNTS, ADDR_DIV2_CTRL, 10'h1E0};
		logic [7:0] rv [6] = '{8'h33, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00};
		logic [7:0] ms [6] = '{8'hFF, 8'hFF, 8'h07, 8'hFF, 8'h80, 8'h00};
		logic [7:0] d;
		chk("dcc at reset", 16'h0001, 16'(dcc));
		for (int i = 0; i < 6; i++) begin
			rreg(ad[i], d);
			chk("reset", 16'(rv[i]), 16'(d));
			wreg(ad[i], 8'hFF);
			rreg(ad[i], d);
			chk("written", 16'(ms[i]), 16'(d));
			wreg(ad[i], rv[i]);
		end
	endtask
	task automatic t_div;
		mchk(0, 32, 32);
		mchk(1, 16, 16);
		wreg(ADDR_DIV1_COUNTS, 8'h12);
		mchk(0, 24, 16);
		wreg(ADDR_DIV2_COUNTS, 8'h20);
		mchk(1, 8, 24);
		wreg(ADDR_DIV2_CTRL, 8'h80);
		mchk(1, 4, 4);
		wreg(ADDR_DIV2_CTRL, 8'h00);
		wreg(ADDR_DIV2_COUNTS, 8'h11);
		wreg(ADDR_DIV1_COUNTS, 8'h33);
	endtask
	task automatic t_route;
		wreg(ADDR_DIV1_CTRL, 8'h80);
		mchk(0, 4, 4);
		wreg(ADDR_DIV1_CTRL, 8'h00);
		wreg(ADDR_CHAN1_CTRL, 8'h02);
		mchk(0, 4, 4);
		setsel(2'h0);
		mchk(0, 8, 8);
		setsel(2'h1);
		mchk(0, 64, 64);
		setsel(2'h2);
		wreg(ADDR_CHAN1_CTRL, 8'h00);
		mchk(0, 32, 32);
	endtask
	task automatic t_pd;
		int n;
		wreg(ADDR_CHAN1_CTRL, 8'h04);
		repeat (4) @(negedge clk);
		chk("power-down", 16'h0001, 16'(pd));
		run(0, 1'b0, n);
		chk("quiet cycles", 16'h01F4, 16'(n));
		chk("quiet b c", 16'h0000, 16'({gb, gc}));
		wreg(ADDR_CHAN1_CTRL, 8'h01);
		repeat (4) @(negedge clk);
		chk("dcc off", 16'h0000, 16'(dcc));
		chk("power-up", 16'h0000, 16'(pd));
		wreg(ADDR_CHAN1_CTRL, 8'h00);
		repeat (4) @(negedge clk);
		chk("dcc on", 16'h0001, 16'(dcc));
	endtask
	task automatic t_sync;
		int n;
		logic [7:0] cv [3] = '{8'h10, 8'h00, 8'h60};
		logic lv [3] = '{1'b1, 1'b0, 1'b1};
		@(posedge clk);
		sync <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wreg(ADDR_DIV1_CTRL, cv[i]);
			repeat (8) @(negedge clk);
			run(0, lv[i], n);
			chk("static level", 16'h01F4, 16'(n));
		end
		wreg(ADDR_DIV1_CTRL, 8'h40);
		mchk(0, 32, 32);
		wreg(ADDR_DIV1_CTRL, 8'h00);
		@(posedge clk);
		sync <= 1'b0;
	endtask
	task automatic t_phase;
		int t [2];
		for (int i = 0; i < 2; i++) begin
			wreg(ADDR_DIV1_CTRL, i ? 8'h04 : 8'h00);
			@(posedge clk);
			sync <= 1'b1;
			repeat (20) @(negedge clk);
			while (ph[3:0] !== 4'h0)
				@(negedge clk);
			@(posedge clk);
			sync <= 1'b0;
			@(negedge clk);
			run(0, 1'b0, t[i]);
		end
		chk("phase delay", 16'h0020, 16'(t[1] - t[0]));
		wreg(ADDR_DIV1_CTRL, 8'h00);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_div();
		t_route();
		t_pd();
		t_sync();
		t_phase();
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		wrap_up();
	end
endmodule
`default_nettype wire
